/* File: rtl/css_pkg.sv */
package css_pkg;
	// ----------------------------------------
	// source-type codes
	// ----------------------------------------
	localparam logic [3:0] SRC_UNUSED = 4'h0;
	localparam logic [3:0] SRC_CAN_RX = 4'h1;
	localparam logic [3:0] SRC_ANALOG = 4'h2;
	localparam logic [3:0] SRC_PID = 4'h3;
	localparam logic [3:0] SRC_LUT = 4'h4;
	localparam logic [3:0] SRC_LOGIC = 4'h5;
	localparam logic [3:0] SRC_MATH = 4'h6;
	localparam logic [3:0] SRC_CONST = 4'h7;
	localparam logic [3:0] SRC_DTC = 4'h8;
	localparam logic [3:0] SRC_OUT_TGT = 4'h9;
	localparam logic [3:0] SRC_OUT_FB = 4'ha;
	localparam logic [3:0] SRC_SUPPLY = 4'hb;
	localparam logic [3:0] SRC_TEMP = 4'hc;
	localparam logic [3:0] SRC_RX_TMO = 4'hd;
	localparam logic [3:0] SRC_REF_LVL = 4'he;

	// ----------------------------------------
	// instance counts and slot layout
	// ----------------------------------------
	localparam int N_CAN = 5;
	localparam int N_FB4 = 4;
	localparam int N_OUT = 2;
	localparam int N_DTC = 5;
	localparam int N_CONST = 14;
	localparam int N_UCONST = 12;
	localparam int N_SLOT = 29;
	localparam logic [4:0] SLOT_CAN = 5'h00;
	localparam logic [4:0] SLOT_ANALOG = 5'h05;
	localparam logic [4:0] SLOT_PID = 5'h09;
	localparam logic [4:0] SLOT_LUT = 5'h0d;
	localparam logic [4:0] SLOT_LOGIC = 5'h11;
	localparam logic [4:0] SLOT_MATH = 5'h15;
	localparam logic [4:0] SLOT_OUT_TGT = 5'h19;
	localparam logic [4:0] SLOT_OUT_FB = 5'h1b;

	// ----------------------------------------
	// register offsets and fields
	// ----------------------------------------
	localparam logic [11:0] OFS_SEL = 12'h000;
	localparam logic [11:0] OFS_ENABLE = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_VALUE = 12'h00c;
	localparam logic [11:0] OFS_CONST0 = 12'h040;
	localparam logic [11:0] OFS_CONSTN = 12'h06c;
	localparam int SEL_CODE_LSB = 0;
	localparam int SEL_NUM_LSB = 8;
	localparam int SEL_DIG_BIT = 16;
	localparam int SEL_OUTBLK_BIT = 17;
	localparam int EN_CAN_LSB = 0;
	localparam int EN_PID_LSB = 8;
	localparam int EN_LOGIC_LSB = 16;
	localparam int EN_MATH_LSB = 24;
	localparam logic [31:0] RST_SEL = 32'h0000_0000;
	localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
	localparam logic [31:0] RST_CONST = 32'h0000_0000;
	// reference level: on above 90% of nominal
	localparam logic [6:0] REF_PCT = 7'h5a;
	localparam logic [6:0] PCT_FULL = 7'h64;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} css_apb_req_s;

	typedef struct packed {
		logic [N_SLOT-1:0][31:0] value;
		logic [N_SLOT-1:0][31:0] min;
		logic [N_SLOT-1:0][31:0] max;
	} css_src_s;

	typedef struct packed {
		logic [N_DTC-1:0] dtc_state;
		logic [N_DTC-1:0] dtc_spn_nz;
		logic [7:0] supply_v;
		logic [7:0] temp_c;
		logic rx_timeout;
		logic [15:0] ref_mv;
		logic [15:0] ref_nom_mv;
	} css_misc_s;

	typedef struct packed {
		logic [31:0] value;
		logic valid;
		logic state;
	} css_out_s;
endpackage : css_pkg

/* File: rtl/css_selector.sv */
`timescale 1ns/1ps
// Functional notes
// - source code plus instance number select input
// - code zero disables the input entirely
// - CAN receive 1-5, off until enabled
// - codes 2-6 select four-instance blocks
// - PID, logic, math off after reset
// - constants: 1 false, 2 true, rest programmed
// - trouble code valid only with nonzero SPN
// - code nine selects output target 1-2
// - code ten selects output feedback current
// - supply voltage, number is volt threshold
// - temperature, number is degree threshold
// - reception timeout only for output blocks
// - reference level one above 90 percent
// - digital from analog with min/max hysteresis
// - on at max, off at min
module css_selector (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb slave
	input wire css_pkg::css_apb_req_s apb_req,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// source values from function blocks
	input wire css_pkg::css_src_s src,
	input wire css_pkg::css_misc_s misc,
	// selected signal to the consuming block
	output css_pkg::css_out_s sel_out
);
	import css_pkg::*;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// limits are per code so one compare covers every source kind;
	// threshold codes skip the check since any 0..255 number is legal
	// highest legal instance number per code, zero when none
	function automatic logic [7:0] num_max(input logic [3:0] code);
		// threshold codes return 255, the whole field
		case (code)
			SRC_CAN_RX: num_max = 8'(N_CAN);
			SRC_DTC: num_max = 8'(N_DTC);
			SRC_ANALOG, SRC_PID, SRC_LUT, SRC_LOGIC, SRC_MATH: num_max = 8'(N_FB4);
			SRC_CONST: num_max = 8'(N_CONST);
			SRC_OUT_TGT, SRC_OUT_FB: num_max = 8'(N_OUT);
			SRC_SUPPLY, SRC_TEMP: num_max = 8'hff;
			SRC_RX_TMO, SRC_REF_LVL: num_max = 8'h01;
			default: num_max = 8'h00;
		endcase
	endfunction : num_max

	// CAN, function and output blocks share one flat slot array;
	// unlisted codes fall back to slot zero, their value is masked later
	// first slot of a code in the flat source arrays
	function automatic logic [4:0] slot_base(input logic [3:0] code);
		// codes without slots return slot zero
		case (code)
			SRC_CAN_RX: slot_base = SLOT_CAN;
			SRC_ANALOG: slot_base = SLOT_ANALOG;
			SRC_PID: slot_base = SLOT_PID;
			SRC_LUT: slot_base = SLOT_LUT;
			SRC_LOGIC: slot_base = SLOT_LOGIC;
			SRC_MATH: slot_base = SLOT_MATH;
			SRC_OUT_TGT: slot_base = SLOT_OUT_TGT;
			SRC_OUT_FB: slot_base = SLOT_OUT_FB;
			default: slot_base = SLOT_CAN;
		endcase
	endfunction : slot_base

	// ----------------------------------------
	// apb access
	// ----------------------------------------
	// every access takes exactly one wait state: ready rises in the
	// second access cycle, which lets read data leave a flop cleanly
	logic ack_r; // one wait state so prdata can come from a flop
	logic [31:0] prdata_r;
	logic [31:0] sel_r; // selection and mode
	logic [31:0] enable_r; // per-block enables
	logic [31:0] const_r [N_UCONST]; // user constants 3..14

	// address decode; constants sit on word steps from the first entry
	wire access = apb_req.psel & apb_req.penable;
	wire wr_en = access & ack_r & apb_req.pwrite;
	wire [11:0] addr = apb_req.paddr;
	wire addr_const = (addr >= OFS_CONST0) && (addr <= OFS_CONSTN) && (addr[1:0] == 2'b00);
	wire [3:0] const_idx = 4'((addr - OFS_CONST0) >> 2);
	wire addr_known = (addr == OFS_SEL) || (addr == OFS_ENABLE) || (addr == OFS_STATUS) ||
		(addr == OFS_VALUE) || addr_const;
	// status and value are read-only; writes there are refused like unmapped
	wire addr_ro = (addr == OFS_STATUS) || (addr == OFS_VALUE);
	wire bad_acc = ~addr_known | (apb_req.pwrite & addr_ro);

	// error answer shares the ready cycle, no separate abort path;
	// a refused access changes nothing and reads zero
	assign pready = ack_r;
	assign prdata = prdata_r;
	assign pslverr = ack_r & bad_acc;

	// ----------------------------------------
	// selection decode
	// ----------------------------------------
	// fields of the selection word, masked on write so unused bits stay zero
	wire [3:0] code = sel_r[SEL_CODE_LSB +: 4];
	wire [7:0] num = sel_r[SEL_NUM_LSB +: 8];
	// digital mode turns the value into the hysteresis state
	wire dig_mode = sel_r[SEL_DIG_BIT];
	wire out_blk = sel_r[SEL_OUTBLK_BIT];
	// enable bits per block; CAN, PID, logic and math start disabled
	wire [4:0] can_en = enable_r[EN_CAN_LSB +: N_CAN];
	wire [3:0] pid_en = enable_r[EN_PID_LSB +: N_FB4];
	wire [3:0] logic_en = enable_r[EN_LOGIC_LSB +: N_FB4];
	wire [3:0] math_en = enable_r[EN_MATH_LSB +: N_FB4];
	// thresholds take the whole 0..255 field, the rest count from one
	wire thr_code = (code == SRC_SUPPLY) || (code == SRC_TEMP);
	// zero limit marks codes with no legal number at all
	wire [7:0] lim = num_max(code);
	wire num_ok = thr_code ? 1'b1 : ((num != 8'h00) && (num <= lim));
	// timeout source only reaches output blocks
	wire tmo_ok = (code != SRC_RX_TMO) || out_blk;
	// zero-based instance index; meaningless when num is illegal, but then
	// in_use is low and every use below is masked
	wire [2:0] idx = 3'(num - 8'h01);
	wire [4:0] slot = 5'(slot_base(code) + 5'(idx));

	// ----------------------------------------
	// block enables
	// ----------------------------------------
	// enable gate of the addressed block, true for blocks with no enable
	logic blk_en;
	always_comb begin
		// analog, lookup and the rest have no enable of their own
		blk_en = 1'b1;
		case (code)
			SRC_CAN_RX: blk_en = can_en[idx];
			SRC_PID: blk_en = pid_en[idx[1:0]];
			SRC_LOGIC: blk_en = logic_en[idx[1:0]];
			SRC_MATH: blk_en = math_en[idx[1:0]];
			default: blk_en = 1'b1;
		endcase
	end

	// ----------------------------------------
	// input in use
	// ----------------------------------------
	// block enable is kept out of in_use so status can tell a bad pick
	// apart from a block that is simply switched off
	// unused code or an illegal pick disables the input
	wire in_use = (code != SRC_UNUSED) && (code <= SRC_REF_LVL) && num_ok && tmo_ok;

	// ----------------------------------------
	// value, range and validity per code
	// ----------------------------------------
	// reference check is strictly greater, so exactly 90 percent reads off;
	// 23 bits hold 65535 times 100 without overflow
	// 90% test done as ref*100 > nom*90 to avoid a divider
	wire [22:0] ref_scaled = 23'(misc.ref_mv) * 23'(PCT_FULL);
	wire [22:0] nom_scaled = 23'(misc.ref_nom_mv) * 23'(REF_PCT);
	wire ref_high = ref_scaled > nom_scaled;
	// constants 3..14 live in entries 0..11 of the user bank
	wire [3:0] uc_idx = 4'(num - 8'h03);

	// one mux picks value, range and validity together; ranges default
	// to 0..1 so a digital source maps straight onto the hysteresis test
	logic [31:0] raw_val; // selected signal before digital conversion
	logic [31:0] raw_min;
	logic [31:0] raw_max;
	logic raw_ok;
	always_comb begin
		raw_val = 32'h0000_0000;
		raw_min = 32'h0000_0000;
		raw_max = 32'h0000_0001;
		raw_ok = in_use & blk_en;
		// validity starts from the decode and the block enable
		case (code)
			SRC_CAN_RX, SRC_ANALOG, SRC_PID, SRC_LUT, SRC_LOGIC, SRC_MATH,
			SRC_OUT_TGT, SRC_OUT_FB: begin
				// feedback slots already carry milliamps
				raw_val = src.value[slot];
				raw_min = src.min[slot];
				raw_max = src.max[slot];
			end
			SRC_CONST: begin
				// no range on constants, so digital use treats positive values as on
				if (num == 8'h01) begin
					raw_val = 32'h0000_0000;
				end else if (num == 8'h02) begin
					raw_val = 32'h0000_0001;
				end else begin
					raw_val = const_r[uc_idx];
				end
			end
			SRC_DTC: begin
				// state only counts when the code has a parameter number set
				raw_val = {31'h0000_0000, misc.dtc_state[idx]};
				raw_ok = in_use & misc.dtc_spn_nz[idx];
			end
			SRC_SUPPLY: begin
				// threshold sits at both edges, so on from threshold up
				raw_val = {24'h00_0000, misc.supply_v};
				raw_min = {24'h00_0000, num};
				raw_max = {24'h00_0000, num};
			end
			SRC_TEMP: begin
				raw_val = {{24{misc.temp_c[7]}}, misc.temp_c};
				raw_min = {24'h00_0000, num};
				raw_max = {24'h00_0000, num};
			end
			SRC_RX_TMO: begin
				// only reached when the consumer is an output block
				raw_val = {31'h0000_0000, misc.rx_timeout};
			end
			SRC_REF_LVL: begin
				// ready-made flag, range stays 0..1
				raw_val = {31'h0000_0000, ref_high};
			end
			default: begin
				raw_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// digital interpretation with hysteresis
	// ----------------------------------------
	// range bounds are compared signed so negative temperatures and
	// offsets behave; equal min and max resolve to on, max test first
	logic state_r; // held between min and max
	logic [31:0] last_sel_r; // selection seen last cycle
	wire at_max = $signed(raw_val) >= $signed(raw_max);
	wire at_min = $signed(raw_val) <= $signed(raw_min);
	wire sel_changed = last_sel_r != sel_r;
	logic state_nxt;
	always_comb begin
		// priority: disabled, max, min, selection change, then hold
		if (!raw_ok) begin
			state_nxt = 1'b0;
		end else if (at_max) begin
			state_nxt = 1'b1;
		end else if (at_min) begin
			state_nxt = 1'b0;
		end else if (sel_changed) begin
			state_nxt = 1'b0; // a new source starts from off
		end else begin
			state_nxt = state_r;
		end
	end

	// output word: plain value, or the on/off state in digital mode;
	// a disabled input shows zero everywhere
	css_out_s out_nxt;
	always_comb begin
		// valid follows the raw check, not the digital state
		out_nxt.valid = raw_ok;
		out_nxt.state = state_nxt;
		out_nxt.value = raw_ok ? (dig_mode ? {31'h0000_0000, state_nxt} : raw_val) : 32'h0000_0000;
	end

	// ----------------------------------------
	// read data mux
	// ----------------------------------------
	// status mixes registered outputs with live decode bits, so a read
	// right after a selection write may show the new code with old state
	logic [31:0] rd_mux;
	always_comb begin
		// unmapped addresses read zero; the error flag tells them apart
		rd_mux = 32'h0000_0000;
		if (addr == OFS_SEL) begin
			rd_mux = sel_r;
		end else if (addr == OFS_ENABLE) begin
			rd_mux = enable_r;
		end else if (addr == OFS_STATUS) begin
			rd_mux = {24'h00_0000, code, 1'b0, ~in_use, sel_out.state, sel_out.valid};
		end else if (addr == OFS_VALUE) begin
			rd_mux = sel_out.value;
		end else if (addr_const) begin
			rd_mux = const_r[const_idx];
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// prdata is forced to zero outside the answer cycle,
	// which keeps the shared read bus quiet between transfers
	// bus handshake and read capture
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= access & ~ack_r;
			prdata_r <= (access & ~ack_r & ~apb_req.pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// writes land only on the ready edge, so a setup cycle never commits;
	// the masks keep reserved bits reading zero
	// selection and enables, read and write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_r <= RST_SEL;
			enable_r <= RST_ENABLE;
		end else begin
			if (wr_en && addr == OFS_SEL) begin
				sel_r <= apb_req.pwdata & 32'h0003_ff0f;
			end
			if (wr_en && addr == OFS_ENABLE) begin
				enable_r <= apb_req.pwdata & 32'h0f0f_0f1f;
			end
		end
	end

	// one flop bank per entry, indexed by word offset from the first
	// user constant storage
	generate
		// reset value is zero, so unprogrammed constants read false
		for (genvar g = 0; g < N_UCONST; g++) begin : g_const
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					const_r[g] <= RST_CONST;
				end else if (wr_en && addr_const && const_idx == 4'(g)) begin
					const_r[g] <= apb_req.pwdata;
				end
			end
		end
	endgenerate

	// last selection is kept to notice a change and restart hysteresis off;
	// the output lags its inputs by exactly one clock
	// selected output and hysteresis state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= 1'b0;
			last_sel_r <= RST_SEL;
			sel_out <= '0;
		end else begin
			state_r <= state_nxt;
			last_sel_r <= sel_r;
			sel_out <= out_nxt;
		end
	end
endmodule : css_selector

/* File: verification/css_src_model.sv */
`timescale 1ns/1ps
// far-side function blocks: fixed pattern plus one swept level
module css_src_model (
	// level under test
	input wire logic [31:0] lvl,
	// source buses
	output css_pkg::css_src_s src,
	output css_pkg::css_misc_s misc
);
	import css_pkg::*;
	// slot i shows 0x100+i so a wrong slot pick is visible; slot 5 follows lvl
	always_comb begin
		for (int i = 0; i < N_SLOT; i++) begin
			src.value[i] = 32'h100 + 32'(i);
			src.min[i] = 32'h10;
			src.max[i] = 32'h20;
		end
		src.value[5] = lvl;
		// all trouble states on, only odd entries carry a parameter number
		misc.dtc_state = 5'h1f;
		misc.dtc_spn_nz = 5'h15;
		misc.supply_v = lvl[7:0];
		misc.temp_c = lvl[7:0];
		misc.rx_timeout = 1'b1;
		misc.ref_mv = lvl[15:0];
		misc.ref_nom_mv = 16'h1388;
	end
endmodule : css_src_model

/* File: verification/css_selector_props.sv */
`timescale 1ns/1ps
module css_selector_props (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb side
	input wire css_pkg::css_apb_req_s apb_req,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// selector side
	input wire css_pkg::css_src_s src,
	input wire css_pkg::css_misc_s misc,
	input wire css_pkg::css_out_s sel_out
);
	import css_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// shadow of the last accepted selection write
	logic [31:0] sel_w_r;
	wire logic wr_sel = apb_req.psel && apb_req.penable && pready && apb_req.pwrite
		&& apb_req.paddr == OFS_SEL && !pslverr;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) sel_w_r <= '0;
		else if (wr_sel) sel_w_r <= apb_req.pwdata;
	end
	wire logic [3:0] s_code = sel_w_r[3:0];
	wire logic [7:0] s_num = sel_w_r[15:8];
	a_ready_wait: assert property ($rose(apb_req.penable) && apb_req.psel |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_one: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_req: assert property (pready |-> apb_req.psel && apb_req.penable)
		else $error("ready without access");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_err_ro: assert property (pready && apb_req.pwrite
		&& (apb_req.paddr == OFS_STATUS || apb_req.paddr == OFS_VALUE) |-> pslverr)
		else $error("read-only write accepted");
	a_unused_off: assert property (s_code == SRC_UNUSED |=> !sel_out.valid && sel_out.value == 0)
		else $error("unused input not disabled");
	a_bad_num: assert property (s_code == SRC_CONST && (s_num == 0 || s_num > 14)
		|=> !sel_out.valid && sel_out.value == 0)
		else $error("bad number not disabled");
	a_const_true: assert property (s_code == SRC_CONST && s_num == 2
		|=> sel_out.valid && sel_out.value == 32'h1)
		else $error("true constant wrong");
endmodule : css_selector_props

/* File: verification/test_control_source_selector.sv */
`timescale 1ns/1ps
module test_control_source_selector;
	import css_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	css_apb_req_s req = '0;
	logic pready, pslverr, er;
	logic [31:0] prdata, rd, prev;
	logic [31:0] lvl = 32'h0;
	css_src_s src;
	css_misc_s misc;
	css_out_s sel_out;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [31:0] rt [20][4]; // enable, select, value, valid
	logic [31:0] dt [11][3]; // select, level, state
	css_selector u_css_selector (.clk(clk), .reset_n(reset_n), .apb_req(req), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .src(src), .misc(misc), .sel_out(sel_out));
	css_src_model u_css_src_model (.lvl(lvl), .src(src), .misc(misc));
	initial forever #4 clk = ~clk;
	// hang guard, far above the roughly 520 cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end
	// one apb transfer; answer taken at the ready edge only
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		req <= '0;
	endtask : apb
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rt = '{'{32'h0, 32'h0, 32'h0, 32'h0},
			'{32'h0, 32'h0101, 32'h0, 32'h0},
			'{32'h1, 32'h0101, 32'h100, 32'h1},
			'{32'h0, 32'h0601, 32'h0, 32'h0},
			'{32'h0, 32'h0202, 32'h106, 32'h1},
			'{32'h0, 32'h0404, 32'h110, 32'h1},
			'{32'h0, 32'h0103, 32'h0, 32'h0},
			'{32'h100, 32'h0103, 32'h109, 32'h1},
			'{32'h08000000, 32'h0406, 32'h118, 32'h1},
			'{32'h0, 32'h0107, 32'h0, 32'h1},
			'{32'h0, 32'h0207, 32'h1, 32'h1},
			'{32'h0, 32'h0307, 32'h55, 32'h1},
			'{32'h0, 32'h0f07, 32'h0, 32'h0},
			'{32'h0, 32'h0108, 32'h1, 32'h1},
			'{32'h0, 32'h0208, 32'h0, 32'h0},
			'{32'h0, 32'h0209, 32'h11a, 32'h1},
			'{32'h0, 32'h010a, 32'h11b, 32'h1},
			'{32'h0, 32'h010d, 32'h0, 32'h0},
			'{32'h0, 32'h2010d, 32'h1, 32'h1},
			'{32'h0, 32'h0002, 32'h0, 32'h0}};
		dt = '{'{32'h300b, 32'h30, 32'h1}, '{32'h300b, 32'h2f, 32'h0},
			'{32'h100c, 32'h10, 32'h1}, '{32'h100c, 32'h0f, 32'h0},
			'{32'h010e, 32'h1195, 32'h1}, '{32'h010e, 32'h1194, 32'h0},
			'{32'h10102, 32'h18, 32'h0}, '{32'h10102, 32'h20, 32'h1},
			'{32'h10102, 32'h18, 32'h1}, '{32'h10102, 32'h10, 32'h0},
			'{32'h10102, 32'h18, 32'h0}};
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, OFS_SEL, 32'h0);
		chk(rd, RST_SEL);
		apb(1'b0, OFS_ENABLE, 32'h0);
		chk(rd, RST_ENABLE);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h1);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, OFS_CONST0, 32'h55);
		apb(1'b0, OFS_CONST0, 32'h0);
		chk(rd, 32'h55);
		$display("test registers done");
		// each row: enables, selection, then readback of value and valid
		for (int i = 0; i < 20; i++) begin
			apb(1'b1, OFS_ENABLE, rt[i][0]);
			apb(1'b1, OFS_SEL, rt[i][1]);
			apb(1'b0, OFS_SEL, 32'h0);
			chk(rd, rt[i][1]);
			apb(1'b0, OFS_VALUE, 32'h0);
			chk(rd, rt[i][2]);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk({31'h0, rd[0]}, rt[i][3]);
			chk({28'h0, rd[7:4]}, {28'h0, rt[i][1][3:0]});
		end
		$display("test selection done");
		// selection rewritten only on change, so hysteresis hold survives
		prev = 32'h0;
		for (int i = 0; i < 11; i++) begin
			lvl <= dt[i][1];
			if (dt[i][0] !== prev) apb(1'b1, OFS_SEL, dt[i][0]);
			prev = dt[i][0];
			repeat (2) @(posedge clk);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk({31'h0, rd[1]}, dt[i][2]);
		end
		$display("test thresholds done");
		conclude();
	end
endmodule : test_control_source_selector
bind css_selector css_selector_props u_props (.clk(clk), .reset_n(reset_n), .apb_req(apb_req),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .src(src), .misc(misc),
	.sel_out(sel_out));
